// ===== rbc_bit_check.v
// Bit-check validator and DATA shaper of the receiver digital path
`include "rbc_map.vh"
module rbc_bit_check #(
	parameter STARTUP_TICKS = `RBC_STARTUP_TICKS,
	parameter MIN_SPACE     = `RBC_MIN_SPACE,
	parameter MAX_LOW       = `RBC_MAX_LOW
) (
	input  wire                 sys_clk,
	input  wire                 resetn,
	input  wire                 base_tick,
	input  wire [1:0]           baud_range_sel,
	input  wire [1:0]           bit_check_count,
	input  wire [`RBC_LIM_W-1:0] lower_window_limit,
	input  wire [`RBC_LIM_W-1:0] upper_window_limit,
	input  wire                 noise_blank_en,
	input  wire                 sleep_done,
	input  wire                 poll_cmd,
	input  wire                 demod_output,
	output reg                  proc_enable_r,
	output reg                  receiving_r,
	output reg                  check_fail_r,
	output reg                  data_out_r,
	output reg                  data_oe_r
);
	localparam ST_SLEEP = 2'h0;
	localparam ST_START = 2'h1;
	localparam ST_CHECK = 2'h2;
	localparam ST_RECV  = 2'h3;

	wire xtick;
	reg  [1:0]            state_r;
	reg  [`RBC_CNT_W-1:0] edge_interval_counter;
	reg  [`RBC_IVL_W-1:0] accepted_r;
	reg  [`RBC_CNT_W-1:0] start_cnt_r;
	reg                   demod_s_r;
	reg                   demod_prev_r;
	reg  [`RBC_CNT_W-1:0] space_cnt_r;
	reg  [`RBC_CNT_W-1:0] low_cnt_r;
	reg                   shaped_r;
	reg                   low_limited_r;

	rbc_tick_div u_div (
		.sys_clk        (sys_clk),
		.resetn         (resetn),
		.base_tick      (base_tick),
		.baud_range_sel (baud_range_sel),
		.xtick_r        (xtick)
	);

	// Required accepted intervals for the selected bit count
	function [`RBC_IVL_W-1:0] need_ivl;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: need_ivl = `RBC_BITS_SEL0;
				2'h1: need_ivl = `RBC_BITS_SEL1;
				2'h2: need_ivl = `RBC_BITS_SEL2;
				default: need_ivl = `RBC_BITS_SEL3;
			endcase
		end
	endfunction

	wire [`RBC_CNT_W-1:0] lim_lo = {1'b0, lower_window_limit};
	wire [`RBC_CNT_W-1:0] lim_hi = {1'b0, upper_window_limit};
	wire edge_seen = xtick && (demod_s_r != demod_prev_r);
	wire passed    = (accepted_r == need_ivl(bit_check_count));

	// Synchronise demodulator output to extended tick
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			demod_s_r    <= 1'b1;
			demod_prev_r <= 1'b1;
		end else if (xtick) begin
			demod_prev_r <= demod_s_r;
			demod_s_r    <= demod_output;
		end
	end

	// Polling sequencer and bit check
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r               <= ST_SLEEP;
			edge_interval_counter <= 6'h00;
			accepted_r            <= 5'h00;
			start_cnt_r           <= 6'h00;
			proc_enable_r         <= 1'b0;
			receiving_r           <= 1'b0;
			check_fail_r          <= 1'b0;
		end else begin
			check_fail_r <= 1'b0;
			case (state_r)
				ST_SLEEP: begin
					proc_enable_r <= 1'b0;
					accepted_r    <= 5'h00;
					if (sleep_done) begin
						state_r       <= ST_START;
						start_cnt_r   <= 6'h00;
						proc_enable_r <= 1'b1;
					end
				end
				ST_START: begin
					// Demodulator undefined here, so edges are ignored
					if (xtick) begin
						if (start_cnt_r >= STARTUP_TICKS[`RBC_CNT_W-1:0] - 6'h01) begin
							state_r               <= ST_CHECK;
							edge_interval_counter <= 6'h00;
						end else begin
							start_cnt_r <= start_cnt_r + 6'h01;
						end
					end
				end
				ST_CHECK: begin
					if (passed) begin
						state_r     <= ST_RECV;
						receiving_r <= 1'b1;
					end else if (xtick) begin
						if (edge_seen && edge_interval_counter < lim_lo) begin
							state_r      <= ST_SLEEP;
							check_fail_r <= 1'b1;
							accepted_r   <= 5'h00;
						end else if (edge_interval_counter + 6'h01 >= lim_hi) begin
							// Timeout fails without waiting for an edge, so a
							// failing check does not scale with bit count
							state_r      <= ST_SLEEP;
							check_fail_r <= 1'b1;
							accepted_r   <= 5'h00;
						end else if (edge_seen) begin
							edge_interval_counter <= 6'h00;
							accepted_r            <= accepted_r + 5'h01;
						end else begin
							edge_interval_counter <= edge_interval_counter + 6'h01;
						end
					end
					if (check_fail_r)
						proc_enable_r <= 1'b0;
				end
				ST_RECV: begin
					if (poll_cmd) begin
						state_r       <= ST_SLEEP;
						receiving_r   <= 1'b0;
						proc_enable_r <= 1'b0;
					end
				end
				default: state_r <= ST_SLEEP;
			endcase
		end
	end

	// Output shaper: minimum edge spacing and low-time limit
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			shaped_r      <= 1'b1;
			space_cnt_r   <= 6'h00;
			low_cnt_r     <= 6'h00;
			low_limited_r <= 1'b0;
		end else if (xtick) begin
			if (space_cnt_r != 6'h3F)
				space_cnt_r <= space_cnt_r + 6'h01;
			if (demod_s_r)
				low_limited_r <= 1'b0;
			if (demod_s_r != shaped_r && !(low_limited_r && !demod_s_r)
					&& space_cnt_r >= MIN_SPACE[`RBC_CNT_W-1:0] - 6'h01) begin
				shaped_r    <= demod_s_r;
				space_cnt_r <= 6'h00;
				low_cnt_r   <= 6'h00;
			end else if (!shaped_r) begin
				if (low_cnt_r >= MAX_LOW[`RBC_CNT_W-1:0] - 6'h01) begin
					shaped_r      <= 1'b1;
					low_limited_r <= 1'b1;
					space_cnt_r   <= 6'h00;
					low_cnt_r     <= 6'h00;
				end else begin
					low_cnt_r <= low_cnt_r + 6'h01;
				end
			end
		end
	end

	// DATA pin drive, open-drain style: enable means pulling low
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_out_r <= 1'b1;
			data_oe_r  <= 1'b0;
		end else begin
			data_out_r <= 1'b0;
			if (receiving_r)
				data_oe_r <= ~shaped_r;
			else if (!noise_blank_en && proc_enable_r)
				data_oe_r <= ~shaped_r;
			else
				data_oe_r <= 1'b0;
		end
	end
endmodule

// ===== rbc_map.vh
// Constants for the bit-check validator and data shaper
`ifndef RBC_MAP_VH
`define RBC_MAP_VH
`define RBC_LIM_W        5
`define RBC_CNT_W        6
`define RBC_IVL_W        5
`define RBC_DIV_W        3
`define RBC_DIV_BR0      3'h7
`define RBC_DIV_BR1      3'h3
`define RBC_DIV_BR2      3'h1
`define RBC_DIV_BR3      3'h0
`define RBC_CHECKS_PER_BIT 2
`define RBC_BITS_SEL0    5'h00
`define RBC_BITS_SEL1    5'h06
`define RBC_BITS_SEL2    5'h0C
`define RBC_BITS_SEL3    5'h12
`define RBC_STARTUP_TICKS 6'h10
`define RBC_MIN_SPACE    6'h04
`define RBC_MAX_LOW      6'h30
`endif

// ===== rbc_tick_div.v
// Extended-tick divider: one-cycle enable every 8, 4, 2 or 1 base ticks
`include "rbc_map.vh"
module rbc_tick_div (
	input  wire       sys_clk,
	input  wire       resetn,
	input  wire       base_tick,
	input  wire [1:0] baud_range_sel,
	output reg        xtick_r
);
	reg [`RBC_DIV_W-1:0] cnt_r;
	reg [`RBC_DIV_W-1:0] top;

	always @* begin
		case (baud_range_sel)
			2'h0: top = `RBC_DIV_BR0;
			2'h1: top = `RBC_DIV_BR1;
			2'h2: top = `RBC_DIV_BR2;
			default: top = `RBC_DIV_BR3;
		endcase
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r   <= 3'h0;
			xtick_r <= 1'b0;
		end else begin
			xtick_r <= 1'b0;
			if (base_tick) begin
				if (cnt_r >= top) begin
					cnt_r   <= 3'h0;
					xtick_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 3'h1;
				end
			end
		end
	end
endmodule

// ===== rbc_bit_check_sva.sv
// Port checker of the bit-check validator
module rbc_bit_check_sva (
	input wire sys_clk,
	input wire resetn,
	input wire sleep_done,
	input wire poll_cmd,
	input wire noise_blank_en,
	input wire proc_enable_r,
	input wire receiving_r,
	input wire check_fail_r,
	input wire data_oe_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	AST_RX_HOLD: assert property (receiving_r && !poll_cmd |=> receiving_r)
		else $error("rx dropped");
	AST_FAIL_ONE: assert property (check_fail_r |=> !check_fail_r)
		else $error("fail too long");
	AST_FAIL_NO_RX: assert property (check_fail_r |-> !receiving_r)
		else $error("fail in rx");
	AST_FAIL_SLEEP: assert property (check_fail_r && !sleep_done |=> !proc_enable_r)
		else $error("no sleep");
	AST_RX_ON: assert property (receiving_r |-> proc_enable_r)
		else $error("rx disabled");
	AST_WAKE: assert property (sleep_done && !proc_enable_r |=> proc_enable_r)
		else $error("no wake");
	AST_RX_ENTRY: assert property ($rose(receiving_r) |-> $past(proc_enable_r))
		else $error("rx from sleep");
	AST_BLANK: assert property ((noise_blank_en && !receiving_r) [*2] |-> !data_oe_r)
		else $error("not blanked");
	C_RX: cover property ($rose(receiving_r));
	C_FAIL: cover property (check_fail_r);
	C_DATA: cover property (receiving_r && data_oe_r);
endmodule
bind rbc_bit_check rbc_bit_check_sva i_rbc_bit_check_sva (.sys_clk(sys_clk), .resetn(resetn),
	.sleep_done(sleep_done), .poll_cmd(poll_cmd), .noise_blank_en(noise_blank_en),
	.proc_enable_r(proc_enable_r), .receiving_r(receiving_r), .check_fail_r(check_fail_r),
	.data_oe_r(data_oe_r));

// ===== rbc_mcu_model.sv
// Controller side of the pulled-up DATA line
module rbc_mcu_model (
	input  wire       sys_clk,
	input  wire       data_out_r,
	input  wire       data_oe_r,
	output wire       data_wire,
	output reg  [7:0] lo_run
);
	timeunit 1ns;
	timeprecision 100ps;
	// Released line floats to the pull-up level
	assign data_wire = data_oe_r ? data_out_r : 1'b1;
	initial lo_run = 8'h00;
	always @(posedge sys_clk) lo_run <= data_wire ? 8'h00 : lo_run + 8'h01;
endmodule

// ===== rbc_bit_check_bench.sv
// Self-checking bench of the bit-check validator
module rbc_bit_check_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam [5:0] max_low = 6'h08;
	reg        sys_clk, resetn, base_tick, noise_blank_en, sleep_done, poll_cmd, demod_output;
	reg        exp_rx;
	reg  [1:0] baud, nbits;
	reg  [4:0] half;
	reg  [7:0] peak;
	reg  [9:0] rows [0:6];
	wire       proc_en, rx, fail, d_out, d_oe, d_wire;
	wire [7:0] lo_run;
	integer    miscompares = 0, checked = 0, cyc = 0, ph = 0, i, n, n1;
	rbc_bit_check #(.STARTUP_TICKS(6'h02), .MIN_SPACE(6'h02), .MAX_LOW(max_low)) i_rbc_bit_check (
		.sys_clk(sys_clk), .resetn(resetn), .base_tick(base_tick), .baud_range_sel(baud),
		.bit_check_count(nbits), .lower_window_limit(5'h0A), .upper_window_limit(5'h14),
		.noise_blank_en(noise_blank_en), .sleep_done(sleep_done), .poll_cmd(poll_cmd),
		.demod_output(demod_output), .proc_enable_r(proc_en), .receiving_r(rx),
		.check_fail_r(fail), .data_out_r(d_out), .data_oe_r(d_oe));
	rbc_mcu_model i_rbc_mcu_model (.sys_clk(sys_clk), .data_out_r(d_out), .data_oe_r(d_oe),
		.data_wire(d_wire), .lo_run(lo_run));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = !sys_clk;
	end
	// Demodulator: square wave, half period in extended ticks
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		ph = ph + 1;
		if (half != 0 && ph >= half * (8 >> baud)) begin
			ph = 0;
			demod_output <= !demod_output;
		end
		if (cyc == 30000) begin
			miscompares = miscompares + 1;
			summarize;
		end
	end
	task chk(input [7:0] g, input [7:0] e, input [8*10:1] nm);
		checked = checked + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("unexpected %0s exp %0h got %0h", nm, e, g);
		end
	endtask
	task summarize;
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Phase restart keeps the first interval inside the window
	task wake;
		@(posedge sys_clk);
		sleep_done <= 1'b1;
		ph = 0;
		@(posedge sys_clk);
		sleep_done <= 1'b0;
	endtask
	task leave;
		@(posedge sys_clk);
		poll_cmd <= 1'b1;
		@(posedge sys_clk);
		poll_cmd <= 1'b0;
		#1 chk(rx, 8'h00, "poll_exit");
	endtask
	task settle;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n = n + 1;
		end while (rx !== 1'b1 && fail !== 1'b1 && n < 3000);
	endtask
	initial begin
		{base_tick, resetn, sleep_done, poll_cmd, demod_output, noise_blank_en} = 6'h21;
		{baud, nbits, half, exp_rx} = 10'h000;
		// Rows: baud range, bit count, half period, receive expected
		rows[0] = 10'h39D;
		rows[1] = 10'h2DD;
		rows[2] = 10'h19D;
		rows[3] = 10'h001;
		rows[4] = 10'h38C;
		rows[5] = 10'h3FC;
		rows[6] = 10'h080;
		repeat (4) @(posedge sys_clk);
		#1 chk({proc_en, rx, fail, d_out, d_oe}, 8'h02, "reset_outs");
		@(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		#1 chk({proc_en, rx, d_out, d_oe}, 8'h00, "idle_outs");
		for (i = 0; i < 7; i = i + 1) begin
			@(posedge sys_clk);
			{baud, nbits, half, exp_rx} <= rows[i];
			wake;
			settle;
			chk({rx, fail}, {exp_rx, !exp_rx}, "outcome");
			if (rx === 1'b1)
				leave;
		end
		for (i = 1; i < 4; i = i + 1) begin
			@(posedge sys_clk);
			{baud, nbits, half} <= {2'h3, i[1:0], 5'h00};
			wake;
			settle;
			if (i == 1)
				n1 = n;
			chk(n, n1, "fail_time");
		end
		@(posedge sys_clk);
		// Line starts high so the low run begins inside receiving mode
		{nbits, half, demod_output} <= 8'h01;
		wake;
		settle;
		@(posedge sys_clk);
		demod_output <= 1'b0;
		peak = 8'h00;
		repeat (3 * max_low) begin
			@(posedge sys_clk);
			#1 chk(lo_run <= max_low + 1, 8'h01, "low_limit");
			if (lo_run > peak)
				peak = lo_run;
		end
		chk(peak >= max_low - 1, 8'h01, "low_seen");
		chk(d_wire, 8'h01, "released");
		leave;
		summarize;
	end
endmodule
